// file: egsr_param_latch.sv
// Parameter latch: holds a value and loads it on a strobe or follows it
`default_nettype none
module egsr_param_latch #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] value_in,
  input wire logic load_in,
  input wire logic follow_in,
  output logic [WIDTH-1:0] value_out
);
  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;

  assign value_next = (load_in || follow_in) ? value_in : value_reg;
  assign value_out = value_reg;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      value_reg <= '0;
    end
    else
    begin
      value_reg <= value_next;
    end
  end
endmodule
`default_nettype wire

// file: egsr_pkg.sv
// Constants for the exposure and gain status readback register bank
// How it works
// - Latch select clear: exposure values load only at frame overhead period start.
// - Latch select set: frame alignment off, exposure values pass through continuously.
// - Triggered global shutter master with select set: load at each exposure start.
// - Read-only 16-bit field shows the prescale value in use.
// - Read-only 16-bit field shows applied clear duration; frozen in slave mode.
// - Read-only 16-bit field shows applied exposure time; frozen in slave mode.
// - Gain mirrors: column 4:0, front-end 12:5, digital scale factor 11:0.
// - Exposure sync-enable cleared: exposure updates no longer aligned to frame start.
`default_nettype none
package egsr_pkg;
  localparam int unsigned EGSR_ADDR_W = 8;
  localparam int unsigned EGSR_DATA_W = 32;
  localparam int unsigned EGSR_IDX_W = 6;
  localparam int unsigned EGSR_STAT_W = 16;
  localparam int unsigned EGSR_COL_W = 5;
  localparam int unsigned EGSR_AFE_W = 8;
  localparam int unsigned EGSR_DSF_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [EGSR_IDX_W-1:0] IDX_SYNC_CONFIG = 6'h0e;
  localparam logic [EGSR_IDX_W-1:0] IDX_PRESCALE_STATUS = 6'h10;
  localparam logic [EGSR_IDX_W-1:0] IDX_CLEAR_DURATION_STATUS = 6'h11;
  localparam logic [EGSR_IDX_W-1:0] IDX_EXPOSURE_TIME_STATUS = 6'h12;
  localparam logic [EGSR_IDX_W-1:0] IDX_RESERVED_STATUS_A = 6'h13;
  localparam logic [EGSR_IDX_W-1:0] IDX_RESERVED_STATUS_B = 6'h14;
  localparam logic [EGSR_IDX_W-1:0] IDX_ANALOG_AMP_STATUS = 6'h15;
  localparam logic [EGSR_IDX_W-1:0] IDX_DIGITAL_SCALE_STATUS = 6'h16;
  // Field positions
  localparam int unsigned BIT_SYNC_EXPOSURE = 3;
  localparam int unsigned BIT_EXPOSURE_LATCH_SEL = 10;
  localparam int unsigned COL_LSB = 0;
  localparam int unsigned AFE_LSB = 5;
  // Reset values
  localparam logic SYNC_EXPOSURE_RST = 1'h1;
  localparam logic EXPOSURE_LATCH_SEL_RST = 1'h0;
  localparam logic [EGSR_STAT_W-1:0] STATUS_RST = 16'h0000;
  localparam logic [EGSR_DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Byte lanes of the sync configuration bits
  localparam int unsigned LANE_SYNC_EXPOSURE = BIT_SYNC_EXPOSURE / 8;
  localparam int unsigned LANE_EXPOSURE_LATCH_SEL = BIT_EXPOSURE_LATCH_SEL / 8;
endpackage
`default_nettype wire

// file: egsr_readback.sv
// Exposure and gain latching with status readback over AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none
module egsr_readback #(
  parameter int unsigned STAT_W = egsr_pkg::EGSR_STAT_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // AXI4-Lite write address
  input wire logic [egsr_pkg::EGSR_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // AXI4-Lite write data
  input wire logic [egsr_pkg::EGSR_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [egsr_pkg::EGSR_DATA_W/8-1:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read address
  input wire logic [egsr_pkg::EGSR_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // AXI4-Lite read data
  output logic [egsr_pkg::EGSR_DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Sequencer events and mode, same clock domain
  input wire logic frame_overhead_start_in,
  input wire logic frame_start_in,
  input wire logic exposure_start_in,
  input wire logic triggered_gs_master_in,
  input wire logic slave_mode_in,
  // Values written into the configuration registers
  input wire logic [STAT_W-1:0] prescale_cfg_in,
  input wire logic [STAT_W-1:0] clear_duration_cfg_in,
  input wire logic [STAT_W-1:0] exposure_time_cfg_in,
  input wire logic [egsr_pkg::EGSR_COL_W-1:0] column_gain_cfg_in,
  input wire logic [egsr_pkg::EGSR_AFE_W-1:0] afe_gain_cfg_in,
  input wire logic [egsr_pkg::EGSR_DSF_W-1:0] digital_scale_factor_cfg_in,
  // Active values for the exposure and gain logic
  output logic [STAT_W-1:0] prescale_active_out,
  output logic [STAT_W-1:0] clear_duration_active_out,
  output logic [STAT_W-1:0] exposure_time_active_out,
  output logic [egsr_pkg::EGSR_COL_W-1:0] column_gain_active_out,
  output logic [egsr_pkg::EGSR_AFE_W-1:0] afe_gain_active_out,
  output logic [egsr_pkg::EGSR_DSF_W-1:0] digital_scale_factor_active_out
);
  import egsr_pkg::*;

  localparam int unsigned EXP_W = 3 * STAT_W;
  localparam int unsigned GAIN_W = EGSR_COL_W + EGSR_AFE_W + EGSR_DSF_W;

  // Register index of a byte address, and whether the address is mapped
  function automatic logic [EGSR_IDX_W-1:0] reg_index(input logic [EGSR_ADDR_W-1:0] addr);
    reg_index = addr[EGSR_ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [EGSR_ADDR_W-1:0] addr);
    logic [EGSR_IDX_W-1:0] idx;
    idx = reg_index(addr);
    is_mapped = (addr[1:0] == 2'h0) &&
                ((idx == IDX_SYNC_CONFIG) ||
                 ((idx >= IDX_PRESCALE_STATUS) && (idx <= IDX_DIGITAL_SCALE_STATUS)));
  endfunction

  // Software control bits
  logic sync_exposure_reg;
  logic sync_exposure_next;
  logic latch_sel_reg;
  logic latch_sel_next;

  // Write channel state
  logic aw_held_reg;
  logic [EGSR_ADDR_W-1:0] awaddr_reg;
  logic w_held_reg;
  logic [EGSR_DATA_W-1:0] wdata_reg;
  logic [EGSR_DATA_W/8-1:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  // Read channel state
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [EGSR_DATA_W-1:0] rdata_reg;

  // Status mirrors
  logic [STAT_W-1:0] clear_status_reg;
  logic [STAT_W-1:0] clear_status_next;
  logic [STAT_W-1:0] exposure_status_reg;
  logic [STAT_W-1:0] exposure_status_next;

  // Write path decode
  wire aw_fire = s_axi_awvalid_in && s_axi_awready_out;
  wire w_fire = s_axi_wvalid_in && s_axi_wready_out;
  wire aw_have = aw_held_reg || aw_fire;
  wire w_have = w_held_reg || w_fire;
  wire wr_commit = aw_have && w_have && !bvalid_reg;
  wire [EGSR_ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr_in;
  wire [EGSR_DATA_W-1:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata_in;
  wire [EGSR_DATA_W/8-1:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb_in;
  wire wr_mapped = is_mapped(wr_addr);
  wire wr_sync_cfg = wr_commit && wr_mapped && (reg_index(wr_addr) == IDX_SYNC_CONFIG);

  // Read path decode
  wire ar_fire = s_axi_arvalid_in && s_axi_arready_out;
  wire rd_mapped = is_mapped(s_axi_araddr_in);
  wire [EGSR_IDX_W-1:0] rd_idx = reg_index(s_axi_araddr_in);

  // Channel readies: one write and one read in flight at a time
  assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_out = !w_held_reg && !bvalid_reg;
  assign s_axi_arready_out = !rvalid_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign s_axi_rdata_out = rdata_reg;

  // Only the sync configuration word is writable; status words drop writes
  // status writes ignored
  assign sync_exposure_next = (wr_sync_cfg && wr_strb[LANE_SYNC_EXPOSURE]) ?
                              wr_data[BIT_SYNC_EXPOSURE] : sync_exposure_reg;
  assign latch_sel_next = (wr_sync_cfg && wr_strb[LANE_EXPOSURE_LATCH_SEL]) ?
                          wr_data[BIT_EXPOSURE_LATCH_SEL] : latch_sel_reg;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sync_exposure_reg <= SYNC_EXPOSURE_RST;
      latch_sel_reg <= EXPOSURE_LATCH_SEL_RST;
    end
    else
    begin
      sync_exposure_reg <= sync_exposure_next;
      latch_sel_reg <= latch_sel_next;
    end
  end

  // Address and data may arrive in either order; each is parked until both are in
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else
    begin
      aw_held_reg <= aw_have && !wr_commit;
      w_held_reg <= w_have && !wr_commit;
      if (aw_fire)
      begin
        awaddr_reg <= s_axi_awaddr_in;
      end
      if (w_fire)
      begin
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (wr_commit)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_in)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // Exposure latch control
  // Sync-enable off means no frame alignment at all, which overrides the select
  // sync enable cleared
  wire exp_unaligned = !sync_exposure_reg;
  wire exp_load_fot = sync_exposure_reg && !latch_sel_reg && frame_overhead_start_in;
  wire exp_load_trig = sync_exposure_reg && latch_sel_reg && triggered_gs_master_in &&
                       exposure_start_in;
  wire exp_follow = exp_unaligned || (latch_sel_reg && !triggered_gs_master_in);
  // Gains keep their own frame-start alignment
  wire gain_load = frame_start_in;

  wire [EXP_W-1:0] exp_cfg = {prescale_cfg_in, clear_duration_cfg_in, exposure_time_cfg_in};
  wire [EXP_W-1:0] exp_active;
  wire [GAIN_W-1:0] gain_cfg = {digital_scale_factor_cfg_in, afe_gain_cfg_in,
                                column_gain_cfg_in};
  wire [GAIN_W-1:0] gain_active;

  egsr_param_latch #(
    .WIDTH(EXP_W)
  ) u_exposure_latch (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .value_in(exp_cfg),
    .load_in(exp_load_fot || exp_load_trig),
    .follow_in(exp_follow),
    .value_out(exp_active)
  );

  egsr_param_latch #(
    .WIDTH(GAIN_W)
  ) u_gain_latch (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .value_in(gain_cfg),
    .load_in(gain_load),
    .follow_in(1'b0),
    .value_out(gain_active)
  );

  assign prescale_active_out = exp_active[3*STAT_W-1:2*STAT_W];
  assign clear_duration_active_out = exp_active[2*STAT_W-1:STAT_W];
  assign exposure_time_active_out = exp_active[STAT_W-1:0];
  assign column_gain_active_out = gain_active[EGSR_COL_W-1:0];
  assign afe_gain_active_out = gain_active[EGSR_COL_W+EGSR_AFE_W-1:EGSR_COL_W];
  assign digital_scale_factor_active_out = gain_active[GAIN_W-1:EGSR_COL_W+EGSR_AFE_W];

  // In slave mode the exposure timing is driven from outside, so the
  // last master value is held rather than tracking stale configuration
  // clear duration frozen
  assign clear_status_next = slave_mode_in ? clear_status_reg : clear_duration_active_out;
  assign exposure_status_next = slave_mode_in ? exposure_status_reg : exposure_time_active_out;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      clear_status_reg <= STATUS_RST;
      exposure_status_reg <= STATUS_RST;
    end
    else
    begin
      clear_status_reg <= clear_status_next;
      exposure_status_reg <= exposure_status_next;
    end
  end

  // Read data selection
  wire [EGSR_DATA_W-1:0] rd_sync_word;
  wire [EGSR_DATA_W-1:0] rd_prescale_word;
  wire [EGSR_DATA_W-1:0] rd_clear_word;
  wire [EGSR_DATA_W-1:0] rd_exposure_word;
  wire [EGSR_DATA_W-1:0] rd_analog_word;
  wire [EGSR_DATA_W-1:0] rd_digital_word;
  logic [EGSR_DATA_W-1:0] rd_word;

  assign rd_sync_word = RDATA_ZERO | (EGSR_DATA_W'(sync_exposure_reg) << BIT_SYNC_EXPOSURE) |
                        (EGSR_DATA_W'(latch_sel_reg) << BIT_EXPOSURE_LATCH_SEL);
  assign rd_prescale_word = EGSR_DATA_W'(prescale_active_out);
  assign rd_clear_word = EGSR_DATA_W'(clear_status_reg);
  assign rd_exposure_word = EGSR_DATA_W'(exposure_status_reg);
  assign rd_analog_word = (EGSR_DATA_W'(column_gain_active_out) << COL_LSB) |
                          (EGSR_DATA_W'(afe_gain_active_out) << AFE_LSB);
  assign rd_digital_word = EGSR_DATA_W'(digital_scale_factor_active_out);

  always_comb
  begin
    case (rd_idx)
      IDX_SYNC_CONFIG: rd_word = rd_sync_word;
      IDX_PRESCALE_STATUS: rd_word = rd_prescale_word;
      IDX_CLEAR_DURATION_STATUS: rd_word = rd_clear_word;
      IDX_EXPOSURE_TIME_STATUS: rd_word = rd_exposure_word;
      IDX_ANALOG_AMP_STATUS: rd_word = rd_analog_word;
      IDX_DIGITAL_SCALE_STATUS: rd_word = rd_digital_word;
      default: rd_word = RDATA_ZERO;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= RDATA_ZERO;
    end
    else if (ar_fire)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= rd_mapped ? rd_word : RDATA_ZERO;
    end
    else if (s_axi_rready_in)
    begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: egsr_readback_properties.sv
// Port-level checks for the exposure and gain readback block
`default_nettype none
module egsr_readback_properties #(
  parameter int unsigned STAT_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic frame_start_in,
  input wire logic [STAT_W-1:0] exposure_time_cfg_in,
  input wire logic [STAT_W-1:0] exposure_time_active_out,
  input wire logic [STAT_W-1:0] prescale_active_out,
  input wire logic [4:0] column_gain_cfg_in,
  input wire logic [7:0] afe_gain_cfg_in,
  input wire logic [11:0] digital_scale_factor_cfg_in,
  input wire logic [4:0] column_gain_active_out,
  input wire logic [7:0] afe_gain_active_out,
  input wire logic [11:0] digital_scale_factor_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_take;
  logic wr_take;
  logic [24:0] gain_act;
  logic [24:0] gain_cfg;
  assign rd_take = s_axi_arvalid_in && s_axi_arready_out;
  assign wr_take = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  // Read data of gain status is laid out afe above column, digital scale separate
  assign gain_act = {afe_gain_active_out, column_gain_active_out,
    digital_scale_factor_active_out};
  assign gain_cfg = {afe_gain_cfg_in, column_gain_cfg_in, digital_scale_factor_cfg_in};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  property p_exp_value;
    $changed(exposure_time_active_out) |-> exposure_time_active_out == $past(exposure_time_cfg_in);
  endproperty
  a_exp_value: assert property (p_exp_value) else $error("exposure active not from cfg");
  property p_gain_hold;
    $changed(gain_act) |-> $past(frame_start_in);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain changed off frame start");
  property p_gain_load;
    frame_start_in |=> gain_act == $past(gain_cfg);
  endproperty
  a_gain_load: assert property (p_gain_load) else $error("gain not loaded");
  property p_rd_prescale;
    rd_take && s_axi_araddr_in == 8'h40 |=> s_axi_rdata_out == {16'h0, $past(prescale_active_out)};
  endproperty
  a_rd_prescale: assert property (p_rd_prescale) else $error("prescale status wrong");
  property p_rd_amp;
    rd_take && s_axi_araddr_in == 8'h54 |=> s_axi_rdata_out == {19'h0, $past(gain_act[24:12])};
  endproperty
  a_rd_amp: assert property (p_rd_amp) else $error("amp status wrong");
  property p_rd_scale;
    rd_take && s_axi_araddr_in == 8'h58 |=> s_axi_rdata_out == {20'h0, $past(gain_act[11:0])};
  endproperty
  a_rd_scale: assert property (p_rd_scale) else $error("scale status wrong");
  property p_rd_rsvd;
    rd_take && (s_axi_araddr_in == 8'h4c || s_axi_araddr_in == 8'h50) |=> s_axi_rdata_out == 0;
  endproperty
  a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved read not zero");
  property p_wr_status;
    wr_take && s_axi_awaddr_in == 8'h48 |=> s_axi_bvalid_out && s_axi_bresp_out == 2'h0;
  endproperty
  a_wr_status: assert property (p_wr_status) else $error("status write not okay");
  property p_b_refuse;
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("ready while response pending");
  c_gain_load: cover property (frame_start_in);
  c_status_write: cover property (wr_take && s_axi_awaddr_in == 8'h48);
  c_amp_read: cover property (rd_take && s_axi_araddr_in == 8'h54);
endmodule
bind egsr_readback egsr_readback_properties #(.STAT_W(STAT_W)) u_props (
  .clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_araddr_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .frame_start_in,
  .exposure_time_cfg_in, .exposure_time_active_out, .prescale_active_out, .column_gain_cfg_in,
  .afe_gain_cfg_in, .digital_scale_factor_cfg_in, .column_gain_active_out,
  .afe_gain_active_out, .digital_scale_factor_active_out
);
`default_nettype wire

// file: tb.sv
// Register-level testbench for the exposure and gain readback block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import egsr_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic frame_overhead_start_in = 1'b0, frame_start_in = 1'b0, exposure_start_in = 1'b0;
  logic triggered_gs_master_in = 1'b0, slave_mode_in = 1'b0;
  logic [15:0] prescale_cfg_in = 16'h0, clear_duration_cfg_in = 16'h0;
  logic [15:0] exposure_time_cfg_in = 16'h0;
  logic [4:0] column_gain_cfg_in = 5'h0, column_gain_active_out;
  logic [7:0] afe_gain_cfg_in = 8'h0, afe_gain_active_out;
  logic [11:0] digital_scale_factor_cfg_in = 12'h0, digital_scale_factor_active_out;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic [15:0] prescale_active_out, clear_duration_active_out, exposure_time_active_out;
  int errors = 0, samples_checked = 0, cycles = 0;
  egsr_readback uut (
    .clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awprot_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arprot_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .frame_overhead_start_in, .frame_start_in, .exposure_start_in, .triggered_gs_master_in,
    .slave_mode_in, .prescale_cfg_in, .clear_duration_cfg_in, .exposure_time_cfg_in,
    .column_gain_cfg_in, .afe_gain_cfg_in, .digital_scale_factor_cfg_in, .prescale_active_out,
    .clear_duration_active_out, .exposure_time_active_out, .column_gain_active_out,
    .afe_gain_active_out, .digital_scale_factor_active_out
  );
  always #4 clk_in = ~clk_in;
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic hit;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      hit = s_axi_bready_in && s_axi_bvalid_out;
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (hit) chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp_out});
      if (hit) s_axi_bready_in <= 1'b0;
    end while (s_axi_awvalid_in || s_axi_wvalid_in || s_axi_bready_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic hit;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      hit = s_axi_rready_in && s_axi_rvalid_out;
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (hit) chk($sformatf("rdata %h", a), e, s_axi_rdata_out);
      if (hit) chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp_out});
      if (hit) s_axi_rready_in <= 1'b0;
    end while (s_axi_arvalid_in || s_axi_rready_in);
  endtask
  // Bit 0 overhead start, bit 1 frame start, bit 2 exposure start
  task automatic pulse(input logic [2:0] p);
    frame_overhead_start_in <= p[0];
    frame_start_in <= p[1];
    exposure_start_in <= p[2];
    tick(1);
    frame_overhead_start_in <= 1'b0;
    frame_start_in <= 1'b0;
    exposure_start_in <= 1'b0;
    tick(1);
  endtask
  initial
  begin
    tick(20);
    rst_in <= 1'b0;
    tick(1);
    for (int i = 16; i <= 22; i++) rd(8'(i * 4), 32'h0, RESP_OKAY);
    rd(8'h38, 32'h8, RESP_OKAY);
    prescale_cfg_in <= 16'h0055;
    clear_duration_cfg_in <= 16'h0abc;
    exposure_time_cfg_in <= 16'h1234;
    tick(3);
    rd(8'h48, 32'h0, RESP_OKAY);
    pulse(3'h1);
    rd(8'h40, 32'h55, RESP_OKAY);
    rd(8'h44, 32'h0abc, RESP_OKAY);
    rd(8'h48, 32'h1234, RESP_OKAY);
    exposure_time_cfg_in <= 16'h2222;
    pulse(3'h4);
    rd(8'h48, 32'h1234, RESP_OKAY);
    wr(8'h48, 32'hffff_ffff, RESP_OKAY);
    rd(8'h48, 32'h1234, RESP_OKAY);
    wr(8'h80, 32'hffff_ffff, RESP_SLVERR);
    rd(8'h80, 32'h0, RESP_SLVERR);
    wr(8'h38, 32'h408, RESP_OKAY);
    rd(8'h38, 32'h408, RESP_OKAY);
    rd(8'h48, 32'h2222, RESP_OKAY);
    triggered_gs_master_in <= 1'b1;
    exposure_time_cfg_in <= 16'h3333;
    pulse(3'h1);
    rd(8'h48, 32'h2222, RESP_OKAY);
    pulse(3'h4);
    rd(8'h48, 32'h3333, RESP_OKAY);
    triggered_gs_master_in <= 1'b0;
    wr(8'h38, 32'h0, RESP_OKAY);
    exposure_time_cfg_in <= 16'h4444;
    tick(2);
    rd(8'h48, 32'h4444, RESP_OKAY);
    wr(8'h38, 32'h8, RESP_OKAY);
    slave_mode_in <= 1'b1;
    exposure_time_cfg_in <= 16'h5555;
    clear_duration_cfg_in <= 16'h0bbb;
    pulse(3'h1);
    rd(8'h48, 32'h4444, RESP_OKAY);
    rd(8'h44, 32'h0abc, RESP_OKAY);
    chk("exposure active", 32'h5555, {16'h0, exposure_time_active_out});
    chk("clear active", 32'h0bbb, {16'h0, clear_duration_active_out});
    slave_mode_in <= 1'b0;
    tick(2);
    rd(8'h48, 32'h5555, RESP_OKAY);
    rd(8'h44, 32'h0bbb, RESP_OKAY);
    column_gain_cfg_in <= 5'h15;
    afe_gain_cfg_in <= 8'ha5;
    digital_scale_factor_cfg_in <= 12'hc3a;
    pulse(3'h5);
    rd(8'h54, 32'h0, RESP_OKAY);
    pulse(3'h2);
    rd(8'h54, {19'h0, 8'ha5, 5'h15}, RESP_OKAY);
    rd(8'h58, 32'hc3a, RESP_OKAY);
    chk("gain active", {7'h0, 12'hc3a, 8'ha5, 5'h15},
        {7'h0, digital_scale_factor_active_out, afe_gain_active_out, column_gain_active_out});
    // Mid-run reset held two edges so no stale change is seen by the checker
    rst_in <= 1'b1;
    tick(2);
    rst_in <= 1'b0;
    tick(1);
    rd(8'h38, 32'h8, RESP_OKAY);
    rd(8'h48, 32'h0, RESP_OKAY);
    rd(8'h54, 32'h0, RESP_OKAY);
    chk("prescale active", 32'h0, {16'h0, prescale_active_out});
    give_verdict();
  end
endmodule
`default_nettype wire
